// ==== logic/bvir_defs.vh ====
// Constants for the bus vectored interrupt requester.
`ifndef BVIR_DEFS_VH
`define BVIR_DEFS_VH
`define BVIR_CLK_PERIOD_NS   10
`define BVIR_VEC_SETTLE_NS   125
`define BVIR_VEC_SETTLE_CYC  ((`BVIR_VEC_SETTLE_NS) / (`BVIR_CLK_PERIOD_NS))
`define BVIR_VEC_DROP_NS     100
`define BVIR_VEC_DROP_CYC    ((`BVIR_VEC_DROP_NS) / (`BVIR_CLK_PERIOD_NS))
`define BVIR_PASS_MAX_NS     500
`define BVIR_PASS_MAX_CYC    ((`BVIR_PASS_MAX_NS) / (`BVIR_CLK_PERIOD_NS))
`define BVIR_REPLY_MAX_NS    10000
`define BVIR_REPLY_MAX_CYC   ((`BVIR_REPLY_MAX_NS) / (`BVIR_CLK_PERIOD_NS))
`define BVIR_LVL4            2'd0
`define BVIR_LVL5            2'd1
`define BVIR_LVL6            2'd2
`define BVIR_LVL7            2'd3
`define BVIR_ST_IDLE         3'h0
`define BVIR_ST_REQ          3'h1
`define BVIR_ST_PASS         3'h2
`define BVIR_ST_REPLY        3'h3
`define BVIR_ST_DONE         3'h4
`define BVIR_SYNC_STAGES     2
`endif

// ==== logic/bvir_reqgen.v ====
// Request line pattern for the configured priority level.
`timescale 1ns/100ps
`include "bvir_defs.vh"
module bvir_reqgen
(
   input  wire [1:0] i_level,
   input  wire       i_active,
   output reg  [3:0] o_lines
);
   // Bit 0 is level 4, bit 3 is level 7.
   always @*
   begin
      o_lines = 4'h0;
      if (i_active)
      begin
         o_lines[0] = 1'b1;
         case (i_level)
            `BVIR_LVL5: o_lines[1] = 1'b1;
            `BVIR_LVL6: o_lines[2] = 1'b1;
            `BVIR_LVL7:
            begin
               o_lines[2] = 1'b1;
               o_lines[3] = 1'b1;
            end
            default: o_lines[0] = 1'b1;
         endcase
      end
   end
endmodule

// ==== logic/bvir_sync.v ====
// Two-flop synchroniser for one asynchronous bus level.
`timescale 1ns/100ps
module bvir_sync
(
   input  wire i_clock,
   input  wire i_sys_rst,
   input  wire i_async,
   output wire o_sync
);
   reg meta_q;
   reg sync_q;
   always @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end
   assign o_sync = sync_q;
endmodule

// ==== logic/bvir_top.v ====
// Peripheral interrupt requester: request, daisy-chain arbitration and vector reply.
`timescale 1ns/100ps
`include "bvir_defs.vh"
module bvir_top
#(
   parameter VEC_W = 16
)
(
   input  wire             i_clock,
   input  wire             i_sys_rst,
   input  wire             i_int_enable,
   input  wire             i_req_condition,
   input  wire [1:0]       i_level_sel,
   input  wire             i_single_level,
   input  wire             i_position_dependent,
   input  wire [VEC_W-1:0] i_vector,
   input  wire             i_input_strobe,
   input  wire             i_ack_chain_in,
   input  wire             i_request_line_level5,
   input  wire             i_request_line_level6,
   input  wire             i_request_line_level7,
   output reg              o_request_line_level4,
   output reg              o_request_line_level5,
   output reg              o_request_line_level6,
   output reg              o_request_line_level7,
   output reg              o_ack_chain_out,
   output reg              o_slave_reply,
   output reg  [VEC_W-1:0] o_shared_addr_data_lines,
   output reg              o_shared_addr_data_oe_n,
   output reg              o_request_pending
);
   // Inputs here are active-high views of the bus levels; pad inversion is outside.
   wire strobe_s;
   wire ack_s;
   wire rq5_s;
   wire rq6_s;
   wire rq7_s;
   wire [3:0] req_lines;

   reg  [2:0]       state_q;
   reg  [2:0]       state_d;
   reg              block_q;
   reg              block_d;
   reg              strobe_prev_q;
   reg              cond_prev_q;
   reg              pending_q;
   reg              pending_d;
   reg  [VEC_W-1:0] vector_q;

   wire strobe_rise;
   wire cond_rise;
   wire higher_req;
   wire req_active;

   bvir_sync u_sync_strobe
   (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_async   (i_input_strobe),
      .o_sync    (strobe_s)
   );
   bvir_sync u_sync_ack
   (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_async   (i_ack_chain_in),
      .o_sync    (ack_s)
   );
   bvir_sync u_sync_rq5
   (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_async   (i_request_line_level5),
      .o_sync    (rq5_s)
   );
   bvir_sync u_sync_rq6
   (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_async   (i_request_line_level6),
      .o_sync    (rq6_s)
   );
   bvir_sync u_sync_rq7
   (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_async   (i_request_line_level7),
      .o_sync    (rq7_s)
   );

   assign strobe_rise = strobe_s & ~strobe_prev_q;
   assign cond_rise   = i_req_condition & ~cond_prev_q;

   // equal levels resolved by chain position
   assign higher_req = i_single_level | i_position_dependent ? 1'b0 :
                       (i_level_sel == `BVIR_LVL4) ? (rq5_s | rq6_s) :
                       (i_level_sel == `BVIR_LVL5) ? rq6_s :
                       (i_level_sel == `BVIR_LVL6) ? rq7_s : 1'b0;

   // enable and the pending flag gate the request
   assign req_active = pending_q & i_int_enable;

   bvir_reqgen u_reqgen
   (
      .i_level  (i_level_sel),
      .i_active (req_active),
      .o_lines  (req_lines)
   );

   always @*
   begin
      state_d   = state_q;
      block_d   = block_q;
      pending_d = pending_q;
      // a fresh condition edge makes a new request
      if (cond_rise & i_int_enable)
         pending_d = 1'b1;
      case (state_q)
         `BVIR_ST_IDLE:
         begin
            // single-level blocks whenever its own request is active
            // The decision is frozen at the strobe edge, so a request that appears
            // between strobe and acknowledge waits for the next cycle.
            if (strobe_rise)
               block_d = req_active & ~higher_req;
            else if (~strobe_s)
               block_d = 1'b0;
            if (ack_s)
            begin
               if (block_d)
                  state_d = `BVIR_ST_REPLY;
               else
                  state_d = `BVIR_ST_PASS;
            end
         end
         `BVIR_ST_PASS:
         begin
            if (~ack_s & ~strobe_s)
               state_d = `BVIR_ST_IDLE;
         end
         `BVIR_ST_REPLY:
         begin
            if (~strobe_s | ~ack_s)
            begin
               state_d = `BVIR_ST_DONE;
               pending_d = cond_rise & i_int_enable;
            end
         end
         `BVIR_ST_DONE:
         begin
            if (~strobe_s)
            begin
               block_d = 1'b0;
               state_d = `BVIR_ST_IDLE;
            end
         end
         default: state_d = `BVIR_ST_IDLE;
      endcase
   end

   always @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         state_q                  <= `BVIR_ST_IDLE;
         block_q                  <= 1'b0;
         strobe_prev_q            <= 1'b0;
         cond_prev_q              <= 1'b0;
         pending_q                <= 1'b0;
         vector_q                 <= {VEC_W{1'b0}};
         o_request_line_level4    <= 1'b0;
         o_request_line_level5    <= 1'b0;
         o_request_line_level6    <= 1'b0;
         o_request_line_level7    <= 1'b0;
         o_ack_chain_out          <= 1'b0;
         o_slave_reply            <= 1'b0;
         o_shared_addr_data_lines <= {VEC_W{1'b0}};
         o_shared_addr_data_oe_n  <= 1'b1;
         o_request_pending        <= 1'b0;
      end
      else
      begin
         state_q       <= state_d;
         block_q       <= block_d;
         strobe_prev_q <= strobe_s;
         cond_prev_q   <= i_req_condition;
         pending_q     <= pending_d;
         o_request_line_level4 <= req_lines[0] & (state_q != `BVIR_ST_DONE);
         o_request_line_level5 <= req_lines[1] & (state_q != `BVIR_ST_DONE);
         // position-dependent level 7 omits level 6
         o_request_line_level6 <= req_lines[2] & (state_q != `BVIR_ST_DONE) &
                                  ~(i_position_dependent & (i_level_sel == `BVIR_LVL7));
         o_request_line_level7 <= req_lines[3] & (state_q != `BVIR_ST_DONE);
         o_ack_chain_out <= (state_d == `BVIR_ST_PASS) & ack_s & ~block_d;
         if (state_d == `BVIR_ST_REPLY && state_q != `BVIR_ST_REPLY)
            vector_q <= i_vector;
         // reply a few cycles after ack
         o_slave_reply            <= (state_d == `BVIR_ST_REPLY);
         o_shared_addr_data_oe_n  <= ~(state_d == `BVIR_ST_REPLY);
         o_shared_addr_data_lines <= (state_d == `BVIR_ST_REPLY) ?
                                     ((state_q == `BVIR_ST_REPLY) ? vector_q : i_vector) : {VEC_W{1'b0}};
         o_request_pending        <= pending_d;
      end
   end
endmodule

// ==== verif/bvir_proc_model.sv ====
// Processor side of the acknowledge cycle.
`timescale 1ns/100ps
module bvir_proc_model
(
   input  wire        i_clock,
   input  wire        i_reply,
   input  wire [15:0] i_data,
   output reg         o_strobe = 1'b0,
   output reg         o_ack = 1'b0
);
   // strobe then ack
   // Called for every table row, and once with no request pending.
   task run(output reg ok, output reg [15:0] v);
      integer n;
      begin
         o_strobe = 1'b1;
         repeat (15) @(posedge i_clock);
         #1 o_ack = 1'b1;
         for (n = 0; n < 300 && !i_reply; n = n + 1)
            @(posedge i_clock) #1;
         ok = i_reply;
         // Data may settle up to 125 ns after the reply.
         repeat (13) @(posedge i_clock);
         #1 v = i_data;
         o_strobe = 1'b0;
         o_ack = 1'b0;
      end
   endtask
endmodule

// ==== verif/bvir_top_sva.sv ====
// Port assertions for the interrupt requester.
`timescale 1ns/100ps
module bvir_top_sva
#(
   parameter VEC_W = 16
)
(
   input wire             i_clock,
   input wire             i_sys_rst,
   input wire             i_int_enable,
   input wire             i_position_dependent,
   input wire [VEC_W-1:0] i_vector,
   input wire             i_input_strobe,
   input wire             i_ack_chain_in,
   input wire             o_request_line_level4,
   input wire             o_request_line_level5,
   input wire             o_request_line_level6,
   input wire             o_request_line_level7,
   input wire             o_ack_chain_out,
   input wire             o_slave_reply,
   input wire [VEC_W-1:0] o_shared_addr_data_lines,
   input wire             o_shared_addr_data_oe_n
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   a_lvl4_base: assert property (
      (o_request_line_level5 || o_request_line_level6 || o_request_line_level7) |-> o_request_line_level4)
      else $error("level 4 line missing");
   a_lvl7_adds6: assert property (
      o_request_line_level7 && !i_position_dependent && $stable(i_position_dependent) |-> o_request_line_level6)
      else $error("level 6 line missing");
   a_posdep_own: assert property (
      o_request_line_level7 && i_position_dependent && $stable(i_position_dependent) |-> !o_request_line_level6)
      else $error("extra level 6 line");
   a_req_enable: assert property ((!i_int_enable)[*4] |-> !o_request_line_level4)
      else $error("request while disabled");
   a_reply_cause: assert property (
      $rose(o_slave_reply) |-> $past(i_ack_chain_in, 2) && $past(i_input_strobe, 2))
      else $error("reply without acknowledge");
   a_reply_vector: assert property (
      o_slave_reply |-> !o_shared_addr_data_oe_n && o_shared_addr_data_lines == i_vector && !o_ack_chain_out)
      else $error("vector or block wrong");
   a_bus_release: assert property (
      $fell(i_input_strobe) |-> ##[1:4] (!o_slave_reply && o_shared_addr_data_oe_n))
      else $error("bus not released");
   a_pass_delay: assert property (
      $rose(i_ack_chain_in) && !o_request_line_level4 |-> ##[1:50] o_ack_chain_out)
      else $error("acknowledge not passed");
   a_reply_bound: assert property (
      $rose(i_ack_chain_in) && o_request_line_level4 |-> ##[1:1000] (o_slave_reply || o_ack_chain_out))
      else $error("no answer to acknowledge");
   a_drop_served: assert property ($fell(o_slave_reply) |-> ##1 !o_request_line_level4)
      else $error("request kept after service");
   c_reply: cover property ($rose(o_slave_reply));
   c_pass: cover property ($rose(o_ack_chain_out));
   c_lvl7: cover property ($rose(o_request_line_level7));
endmodule
bind bvir_top bvir_top_sva #(.VEC_W(VEC_W)) u_bvir_top_sva (.*);

// ==== verif/tb_top.sv ====
// Self-checking bench for the interrupt requester.
`timescale 1ns/100ps
module tb_top;
   reg         i_clock, i_sys_rst, en, cond, single, posdep, ok, seen;
   reg  [1:0]  lvl;
   reg  [2:0]  hi;
   reg  [15:0] vec, got;
   reg  [11:0] r;
   wire        stb, ack, reply, chain, oe_n, pend;
   wire [3:0]  lines;
   wire [15:0] data;
   integer     bad_count, checks, i;
   // Row fields: level, single, position, higher lines 7..5, own lines 7..4, win.
   localparam [143:0] ROWS = {12'h143, 12'h243, 12'h427, 12'h083, 12'hc9b, 12'h88a,
                              12'h446, 12'h042, 12'hc1b, 12'h80b, 12'h407, 12'h003};
`define CHK(a, e) begin checks = checks + 1; if ((a) !== (e)) begin \
   bad_count = bad_count + 1; $display("BAD %0t value mismatch", $time); end end
   bvir_top #(.VEC_W(16)) u_bvir_top
   (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_int_enable(en), .i_req_condition(cond),
      .i_level_sel(lvl), .i_single_level(single), .i_position_dependent(posdep), .i_vector(vec),
      .i_input_strobe(stb), .i_ack_chain_in(ack), .i_request_line_level5(hi[0]),
      .i_request_line_level6(hi[1]), .i_request_line_level7(hi[2]), .o_request_line_level4(lines[0]),
      .o_request_line_level5(lines[1]), .o_request_line_level6(lines[2]), .o_request_line_level7(lines[3]),
      .o_ack_chain_out(chain), .o_slave_reply(reply), .o_shared_addr_data_lines(data),
      .o_shared_addr_data_oe_n(oe_n), .o_request_pending(pend)
   );
   bvir_proc_model u_bvir_proc_model
   (
      .i_clock(i_clock), .i_reply(reply), .i_data(data), .o_strobe(stb), .o_ack(ack)
   );
   initial
   begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) if (chain) seen = 1'b1;
   task tick(input integer n);
      begin
         repeat (n) @(posedge i_clock);
         #1;
      end
   endtask
   task do_reset;
      begin
         i_sys_rst = 1'b1;
         tick(4);
         i_sys_rst = 1'b0;
         seen = 1'b0;
      end
   endtask
   task raise_req;
      begin
         cond = 1'b1;
         tick(4);
         cond = 1'b0;
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d bad %0d", checks, bad_count);
         if (bad_count == 0 && checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial
   begin
      #200000;
      bad_count = bad_count + 1;
      $display("BAD %0t watchdog expired", $time);
      give_verdict;
   end
   initial
   begin
      bad_count = 0;
      checks = 0;
      {i_sys_rst, en, cond, single, posdep, seen, lvl, hi, vec} = 27'h0;
      for (i = 0; i < 12; i = i + 1)
      begin
         r = ROWS[i*12 +: 12];
         {lvl, single, posdep} = r[11:8];
         vec = {12'h5a3, i[3:0]};
         hi = 3'h0;
         en = 1'b1;
         do_reset;
         raise_req;
         `CHK(lines, r[4:1])
         hi = r[7:5];
         u_bvir_proc_model.run(ok, got);
         `CHK(ok, r[0])
         `CHK(seen, ~r[0])
         if (r[0]) `CHK(got, vec)
         tick(5);
         `CHK(lines, r[0] ? 4'h0 : r[4:1])
         `CHK({reply, oe_n, data}, 18'h10000)
         $display("row %0d done", i);
      end
      do_reset;
      u_bvir_proc_model.run(ok, got);
      `CHK({ok, seen}, 2'h1)
      $display("pass-through done");
      raise_req;
      `CHK(lines[0], 1'b1)
      en = 1'b0;
      tick(4);
      `CHK(lines, 4'h0)
      $display("enable drop done");
      en = 1'b1;
      raise_req;
      i_sys_rst = 1'b1;
      tick(1);
      `CHK({lines, chain, reply, oe_n, data, pend}, 24'h020000)
      i_sys_rst = 1'b0;
      $display("mid-run reset done");
      {lvl, single, posdep} = 4'hd;
      raise_req;
      `CHK(lines, 4'h9)
      $display("position-dependent level 7 done");
      give_verdict;
   end
endmodule
